// [hw/dppa_pkg.sv]
// constants, field positions and state codes of the dual parallel port adapter
// assumes one 200 MHz clock and pins sampled synchronously to it
//
// Summary of operation
// - two independent sides with full register sets
// - write byte held during enable, applied after fall
// - enable alone times every processor transfer
// - data bus driven only during a selected read
// - direction bit one means output, zero input
// - direction registers rewritable anytime, applied at once
// - output lines follow output register bits
// - control access bit picks direction or output register
// - control bits 7 and 6 are interrupt flags
// - four lines, two per side, second also outputs
// - first line set to one of four modes, second line to one of eight
// - active transitions set the matching status flag
// - 00 side A, 10 side B, x1 control
// - read/write low writes, high drives bus data
// - reset input clears all registers to zero
package dppa_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CTL_W = 6;

  // ------------------------------------------------------------
  // register select codes
  // ------------------------------------------------------------
  localparam logic [1:0] RS_SIDE_A = 2'h0;
  localparam logic [1:0] RS_CTRL_A = 2'h1;
  localparam logic [1:0] RS_SIDE_B = 2'h2;
  localparam logic [1:0] RS_CTRL_B = 2'h3;

  // ------------------------------------------------------------
  // control register bit positions
  // ------------------------------------------------------------
  localparam int CTL_IRQ1_EN = 0;
  localparam int CTL_IRQ1_RISE = 1;
  localparam int CTL_ACCESS = 2;
  localparam int CTL_L2_EN = 3;
  localparam int CTL_L2_RISE = 4;
  localparam int CTL_L2_OUT = 5;
  localparam int CTL_FLAG2 = 6;
  localparam int CTL_FLAG1 = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
  localparam logic LINE_IDLE = 1'h1;

  // ------------------------------------------------------------
  // processor bus sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } dppa_bus_state_t;

endpackage

// [hw/dppa_latch.sv]
// holding latch for the processor write byte
// assumes capture is high only while a selected write has enable high
`timescale 1ns/1ps
module dppa_latch (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic capture_i,
  input wire logic [dppa_pkg::DATA_W-1:0] data_i,
  output logic [dppa_pkg::DATA_W-1:0] hold_o
);
  import dppa_pkg::*;

  logic [DATA_W-1:0] next_hold;

  // ------------------------------------------------------------
  // capture while enable high
  // ------------------------------------------------------------
  always_comb begin
    next_hold = hold_o;
    if (clear_i) begin
      next_hold = REG_RESET;
    end else if (capture_i) begin
      next_hold = data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_o <= REG_RESET;
    end else begin
      hold_o <= next_hold;
    end
  end

endmodule

// [hw/dppa_side.sv]
// one side: control, direction and output registers, flags, line control
// assumes write strobes last one cycle and pins are synchronous
`timescale 1ns/1ps
module dppa_side (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic wr_ctrl_i,
  input wire logic wr_dir_i,
  input wire logic wr_out_i,
  input wire logic [dppa_pkg::DATA_W-1:0] wdata_i,
  input wire logic flag_clr_i,
  input wire logic handshake_i,
  input wire logic irq_in_i,
  input wire logic line_in_i,
  output logic [dppa_pkg::DATA_W-1:0] ctrl_o,
  output logic [dppa_pkg::DATA_W-1:0] dir_o,
  output logic [dppa_pkg::DATA_W-1:0] out_data_o,
  output logic int_req_o,
  output logic line_o,
  output logic line_oe_o
);
  import dppa_pkg::*;

  logic [CTL_W-1:0] ctrl, next_ctrl;
  logic [DATA_W-1:0] next_dir, next_out;
  logic flag1, next_flag1, flag2, next_flag2;
  logic irq_q, line_q, next_line, next_int_req;
  logic fire1, fire2;

  // ------------------------------------------------------------
  // edge detection and flags
  // ------------------------------------------------------------
  always_comb begin
    fire1 = ctrl[CTL_IRQ1_RISE] ? (irq_in_i & ~irq_q) : (~irq_in_i & irq_q);
    fire2 = ~ctrl[CTL_L2_OUT] &
            (ctrl[CTL_L2_RISE] ? (line_in_i & ~line_q) : (~line_in_i & line_q));
    next_ctrl = wr_ctrl_i ? wdata_i[CTL_W-1:0] : ctrl;
    next_dir = wr_dir_i ? wdata_i : dir_o;
    next_out = wr_out_i ? wdata_i : out_data_o;
    next_flag1 = fire1 | (flag1 & ~flag_clr_i);
    next_flag2 = fire2 | (flag2 & ~flag_clr_i);
    next_int_req = (flag1 & ctrl[CTL_IRQ1_EN]) |
                   (flag2 & ctrl[CTL_L2_EN] & ~ctrl[CTL_L2_OUT]);
    next_line = LINE_IDLE;
    if (ctrl[CTL_L2_OUT]) begin
      if (ctrl[CTL_L2_RISE]) begin
        next_line = ctrl[CTL_L2_EN];
      end else if (ctrl[CTL_L2_EN]) begin
        next_line = ~handshake_i;
      end else if (handshake_i) begin
        next_line = 1'h0;
      end else if (fire1) begin
        next_line = 1'h1;
      end else begin
        next_line = line_o;
      end
    end
    if (clear_i) begin
      next_ctrl = CTL_RESET;
      next_dir = REG_RESET;
      next_out = REG_RESET;
      next_flag1 = 1'h0;
      next_flag2 = 1'h0;
      next_int_req = 1'h0;
      next_line = LINE_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTL_RESET;
      dir_o <= REG_RESET;
      out_data_o <= REG_RESET;
      flag1 <= 1'h0;
      flag2 <= 1'h0;
      irq_q <= 1'h0;
      line_q <= 1'h0;
      int_req_o <= 1'h0;
      line_o <= LINE_IDLE;
    end else begin
      ctrl <= next_ctrl;
      dir_o <= next_dir;
      out_data_o <= next_out;
      flag1 <= next_flag1;
      flag2 <= next_flag2;
      irq_q <= irq_in_i;
      line_q <= line_in_i;
      int_req_o <= next_int_req;
      line_o <= next_line;
    end
  end

  assign ctrl_o = {flag1, flag2, ctrl};
  assign line_oe_o = ctrl[CTL_L2_OUT];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (fire1 && !clear_i) |=> ctrl_o[CTL_FLAG1])
    else $error("active transition did not set flag");

  AST_INT_REQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (flag1 && ctrl[CTL_IRQ1_EN] && !clear_i) |=> int_req_o)
    else $error("enabled flag did not raise interrupt request");

  AST_LINE_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl[CTL_L2_OUT] && !ctrl[CTL_L2_RISE] && ctrl[CTL_L2_EN] && handshake_i && !clear_i)
      |=> !line_o)
    else $error("port access did not pulse the control line");

endmodule

// [hw/dppa_top.sv]
// dual parallel port adapter: processor bus sequencer, decode and ports
// assumes bus pins, enable and peripheral pins are synchronous to sys_clk_i
`timescale 1ns/1ps
module dppa_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic select_one_i,
  input wire logic select_two_i,
  input wire logic select_three_n_i,
  input wire logic reg_select_low_i,
  input wire logic reg_select_high_i,
  input wire logic read_write_i,
  input wire logic [dppa_pkg::DATA_W-1:0] data_i,
  output logic [dppa_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [dppa_pkg::DATA_W-1:0] port_a_i,
  output logic [dppa_pkg::DATA_W-1:0] port_a_o,
  output logic [dppa_pkg::DATA_W-1:0] port_a_oe_o,
  input wire logic [dppa_pkg::DATA_W-1:0] port_b_i,
  output logic [dppa_pkg::DATA_W-1:0] port_b_o,
  output logic [dppa_pkg::DATA_W-1:0] port_b_oe_o,
  input wire logic side_a_irq_input_i,
  input wire logic side_a_ctrl_line_i,
  output logic side_a_ctrl_line_o,
  output logic side_a_ctrl_line_oe_o,
  output logic side_a_int_request_oe_o,
  input wire logic side_b_irq_input_i,
  input wire logic side_b_ctrl_line_i,
  output logic side_b_ctrl_line_o,
  output logic side_b_ctrl_line_oe_o,
  output logic side_b_int_request_oe_o
);
  import dppa_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  dppa_bus_state_t state, next_state;
  logic [1:0] rs, next_rs, rs_in;
  logic [DATA_W-1:0] next_data;
  logic next_data_oe;
  logic sel, clear;
  logic start, capture, wr_go, rd_go;
  logic [DATA_W-1:0] hold, rd_val;
  logic [DATA_W-1:0] a_ctrl, a_dir, a_out;
  logic [DATA_W-1:0] b_ctrl, b_dir, b_out, b_rd;
  logic wr_ctrl_a, wr_dir_a, wr_out_a;
  logic wr_ctrl_b, wr_dir_b, wr_out_b;
  logic clr_a, clr_b, hs_a, hs_b;

  // ------------------------------------------------------------
  // selection and reset
  // ------------------------------------------------------------
  assign sel = select_one_i & select_two_i & ~select_three_n_i;
  assign rs_in = {reg_select_high_i, reg_select_low_i};
  assign clear = ~reset_n_i;
  assign start = (state == ST_IDLE) & enable_i & sel;

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_rs = rs;
    if (clear) begin
      next_state = ST_IDLE;
      next_rs = 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            next_rs = rs_in;
            next_state = read_write_i ? ST_READ : ST_WRITE;
          end
        end
        ST_READ: begin
          if (!enable_i) begin
            next_state = ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (!enable_i) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      rs <= 2'h0;
    end else begin
      state <= next_state;
      rs <= next_rs;
    end
  end

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  assign capture = ~clear & ((start & ~read_write_i) | ((state == ST_WRITE) & enable_i));
  assign wr_go = ~clear & (state == ST_WRITE) & ~enable_i;
  assign rd_go = ~clear & (state == ST_READ) & ~enable_i;

  dppa_latch u_latch (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear),
    .capture_i(capture),
    .data_i(data_i),
    .hold_o(hold)
  );

  always_comb begin
    wr_ctrl_a = wr_go & (rs == RS_CTRL_A);
    wr_ctrl_b = wr_go & (rs == RS_CTRL_B);
    wr_dir_a = wr_go & (rs == RS_SIDE_A) & ~a_ctrl[CTL_ACCESS];
    wr_out_a = wr_go & (rs == RS_SIDE_A) & a_ctrl[CTL_ACCESS];
    wr_dir_b = wr_go & (rs == RS_SIDE_B) & ~b_ctrl[CTL_ACCESS];
    wr_out_b = wr_go & (rs == RS_SIDE_B) & b_ctrl[CTL_ACCESS];
    hs_a = rd_go & (rs == RS_SIDE_A) & a_ctrl[CTL_ACCESS];
    hs_b = wr_out_b;
    clr_a = hs_a;
    clr_b = rd_go & (rs == RS_SIDE_B) & b_ctrl[CTL_ACCESS];
  end

  // ------------------------------------------------------------
  // the two sides
  // ------------------------------------------------------------
  dppa_side u_side_a (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear),
    .wr_ctrl_i(wr_ctrl_a),
    .wr_dir_i(wr_dir_a),
    .wr_out_i(wr_out_a),
    .wdata_i(hold),
    .flag_clr_i(clr_a),
    .handshake_i(hs_a),
    .irq_in_i(side_a_irq_input_i),
    .line_in_i(side_a_ctrl_line_i),
    .ctrl_o(a_ctrl),
    .dir_o(a_dir),
    .out_data_o(a_out),
    .int_req_o(side_a_int_request_oe_o),
    .line_o(side_a_ctrl_line_o),
    .line_oe_o(side_a_ctrl_line_oe_o)
  );

  dppa_side u_side_b (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear),
    .wr_ctrl_i(wr_ctrl_b),
    .wr_dir_i(wr_dir_b),
    .wr_out_i(wr_out_b),
    .wdata_i(hold),
    .flag_clr_i(clr_b),
    .handshake_i(hs_b),
    .irq_in_i(side_b_irq_input_i),
    .line_in_i(side_b_ctrl_line_i),
    .ctrl_o(b_ctrl),
    .dir_o(b_dir),
    .out_data_o(b_out),
    .int_req_o(side_b_int_request_oe_o),
    .line_o(side_b_ctrl_line_o),
    .line_oe_o(side_b_ctrl_line_oe_o)
  );

  // ------------------------------------------------------------
  // peripheral port drivers
  // ------------------------------------------------------------
  assign port_a_o = a_out;
  assign port_a_oe_o = a_dir;
  assign port_b_o = b_out;
  assign port_b_oe_o = b_dir;

  // side B reads its output register on output lines, pins elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_b_read
      assign b_rd[gi] = b_dir[gi] ? b_out[gi] : port_b_i[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    unique case (rs_in)
      RS_SIDE_A: rd_val = a_ctrl[CTL_ACCESS] ? port_a_i : a_dir;
      RS_CTRL_A: rd_val = a_ctrl;
      RS_SIDE_B: rd_val = b_ctrl[CTL_ACCESS] ? b_rd : b_dir;
      RS_CTRL_B: rd_val = b_ctrl;
    endcase
  end

  always_comb begin
    next_data = data_o;
    if (clear) begin
      next_data = REG_RESET;
    end else if (start & read_write_i) begin
      next_data = rd_val;
    end
    next_data_oe = ~clear & (next_state == ST_READ);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= REG_RESET;
      data_oe_o <= 1'h0;
    end else begin
      data_o <= next_data;
      data_oe_o <= next_data_oe;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking

  default disable iff (rst_i);

  sequence s_write_high;
    (state == ST_WRITE) && enable_i && reset_n_i;
  endsequence

  sequence s_write_fall;
    s_write_high ##1 (!enable_i && reset_n_i);
  endsequence

  sequence s_read_start;
    (state == ST_IDLE) && enable_i && sel && read_write_i && reset_n_i;
  endsequence

  AST_BUS_HIZ: assert property (
    data_oe_o |-> (state == ST_READ))
    else $error("data bus driven outside a read");

  AST_WRITE_AFTER_FALL: assert property (
    s_write_fall |-> wr_go)
    else $error("write not applied at enable fall");

  AST_NO_EARLY_WRITE: assert property (
    wr_go |-> (!enable_i && $past(enable_i)))
    else $error("register written while enable high");

  AST_READ_DRIVE: assert property (
    s_read_start |=> (state == ST_READ) && data_oe_o)
    else $error("selected read did not drive the bus");

  AST_READ_STABLE: assert property (
    ((state == ST_READ) && $past(state) == ST_READ) |-> $stable(data_o))
    else $error("read data changed during enable high");

  AST_DIR_APPLY: assert property (
    (wr_go && rs == RS_SIDE_A && !a_ctrl[CTL_ACCESS]) |=> port_a_oe_o == $past(hold))
    else $error("direction write not applied to port A");

  AST_OUT_APPLY: assert property (
    (wr_go && rs == RS_SIDE_B && b_ctrl[CTL_ACCESS]) |=> port_b_o == $past(hold))
    else $error("output write not applied to port B");

  AST_SEL_GATE: assert property (
    ((state == ST_IDLE) && !sel) |=> (state == ST_IDLE) && !data_oe_o)
    else $error("unselected access was taken");

  AST_RESET_CLEAR: assert property (
    !reset_n_i |=> (port_a_oe_o == REG_RESET) && (port_b_o == REG_RESET) && !data_oe_o)
    else $error("reset input did not clear registers");

  AST_READ_RELEASE: assert property (
    ((state == ST_READ) && !enable_i) |=> !data_oe_o)
    else $error("data bus still driven after enable fell");

  AST_HOLD_CAPTURE: assert property (
    ((state == ST_WRITE) && enable_i && reset_n_i) |=> (hold == $past(data_i)))
    else $error("write byte not held while enable high");

  AST_PORT_A_PINS: assert property (
    (start && read_write_i && reset_n_i && (rs_in == RS_SIDE_A) && a_ctrl[CTL_ACCESS])
      |=> (data_o == $past(port_a_i)))
    else $error("port A read did not return the pins");

  AST_DIR_A_READ: assert property (
    (start && read_write_i && reset_n_i && (rs_in == RS_SIDE_A) && !a_ctrl[CTL_ACCESS])
      |=> (data_o == port_a_oe_o))
    else $error("direction A read returned a wrong value");

  AST_PORT_B_OUT_BITS: assert property (
    (start && read_write_i && reset_n_i && (rs_in == RS_SIDE_B) && b_ctrl[CTL_ACCESS])
      |=> (((data_o ^ port_b_o) & port_b_oe_o) == 8'h00))
    else $error("port B read did not return output register bits");

endmodule

// [tb/dppa_cpu_model.sv]
// processor bus master model: selects, register selects, read/write, enable
// assumes the testbench calls its tasks from one process, at falling edges
`timescale 1ns/1ps
module dppa_cpu_model (
  input wire logic sys_clk_i,
  input wire logic [dppa_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_oe_i,
  output logic enable_o,
  output logic select_one_o,
  output logic select_two_o,
  output logic select_three_n_o,
  output logic reg_select_low_o,
  output logic reg_select_high_o,
  output logic read_write_o,
  output logic [dppa_pkg::DATA_W-1:0] wdata_o
);
  import dppa_pkg::*;

  // ------------------------------------------------------------
  // idle bus
  // ------------------------------------------------------------
  initial begin
    enable_o = 1'h0;
    select_one_o = 1'h0;
    select_two_o = 1'h0;
    select_three_n_o = 1'h1;
    reg_select_low_o = 1'h0;
    reg_select_high_o = 1'h0;
    read_write_o = 1'h1;
    wdata_o = 8'h00;
  end

  // ------------------------------------------------------------
  // access phases
  // ------------------------------------------------------------
  // raise a request after a falling edge, then let one rising edge take it
  task automatic bus_on(input logic sel, input logic rw, input logic [1:0] rs,
                        input logic [DATA_W-1:0] d);
    @(negedge sys_clk_i);
    select_one_o = 1'h1;
    select_two_o = sel;
    select_three_n_o = 1'h0;
    {reg_select_high_o, reg_select_low_o} = rs;
    read_write_o = rw;
    wdata_o = rw ? ~d : d;
    enable_o = 1'h1;
    @(negedge sys_clk_i);
  endtask

  // drop enable, hold the rest one more cycle, then release the bus
  task automatic bus_off();
    enable_o = 1'h0;
    @(negedge sys_clk_i);
    select_one_o = 1'h0;
    select_two_o = 1'h0;
    select_three_n_o = 1'h1;
    read_write_o = 1'h1;
    wdata_o = ~wdata_o;
    @(negedge sys_clk_i);
  endtask

  // read: wait bounded for the drive, sample twice while enable is high
  task automatic bus_read(input logic [1:0] rs, output logic [DATA_W-1:0] val,
                          output logic ok);
    logic [DATA_W-1:0] first;
    ok = 1'h0;
    val = 8'h00;
    bus_on(1'h1, 1'h1, rs, 8'h00);
    for (int n = 0; n < 8 && !ok; n++) begin
      if (rd_oe_i === 1'h1) begin
        ok = 1'h1;
      end else begin
        @(negedge sys_clk_i);
      end
    end
    first = rd_data_i;
    @(negedge sys_clk_i);
    val = (first === rd_data_i && rd_oe_i === 1'h1) ? first : 8'hXX;
    bus_off();
  endtask
endmodule

// [tb/tb_dual_parallel_port_adapter.sv]
// self-checking bench for the dual parallel port adapter
// assumes dppa_top, dppa_pkg and the processor model are compiled first
`timescale 1ns/1ps
module tb_dual_parallel_port_adapter;
  import dppa_pkg::*;

  // ------------------------------------------------------------
  // nets and pin resolution
  // ------------------------------------------------------------
  logic sys_clk_i, rst_i, reset_n_i;
  logic en, s1, s2, s3_n, rsl, rsh, rw;
  logic [7:0] wd, data_o, port_a_o, port_a_oe_o, port_b_o, port_b_oe_o;
  logic data_oe_o, a_line_o, a_line_oe_o, a_irq_oe_o, b_line_o, b_line_oe_o, b_irq_oe_o;
  logic [7:0] ext_a, ext_b;
  logic a_irq, b_irq, ext_a_line, ext_b_line;
  int errors, samples_checked;
  logic [7:0] modes [4] = '{8'h00, 8'h28, 8'h38, 8'h30};
  logic [1:0] mode_exp [4] = '{2'h1, 2'h3, 2'h3, 2'h2};
  wire [7:0] port_a_i = (port_a_oe_o & port_a_o) | (~port_a_oe_o & ext_a);
  wire [7:0] port_b_i = (port_b_oe_o & port_b_o) | (~port_b_oe_o & ext_b);
  wire a_line_i = a_line_oe_o ? a_line_o : ext_a_line;
  wire b_line_i = b_line_oe_o ? b_line_o : ext_b_line;

  dppa_cpu_model u_cpu (.sys_clk_i(sys_clk_i), .rd_data_i(data_o), .rd_oe_i(data_oe_o),
    .enable_o(en), .select_one_o(s1), .select_two_o(s2), .select_three_n_o(s3_n),
    .reg_select_low_o(rsl), .reg_select_high_o(rsh), .read_write_o(rw), .wdata_o(wd));

  dppa_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .enable_i(en), .select_one_i(s1), .select_two_i(s2), .select_three_n_i(s3_n),
    .reg_select_low_i(rsl), .reg_select_high_i(rsh), .read_write_i(rw), .data_i(wd),
    .data_o(data_o), .data_oe_o(data_oe_o), .port_a_i(port_a_i), .port_a_o(port_a_o),
    .port_a_oe_o(port_a_oe_o), .port_b_i(port_b_i), .port_b_o(port_b_o),
    .port_b_oe_o(port_b_oe_o), .side_a_irq_input_i(a_irq), .side_a_ctrl_line_i(a_line_i),
    .side_a_ctrl_line_o(a_line_o), .side_a_ctrl_line_oe_o(a_line_oe_o),
    .side_a_int_request_oe_o(a_irq_oe_o), .side_b_irq_input_i(b_irq),
    .side_b_ctrl_line_i(b_line_i), .side_b_ctrl_line_o(b_line_o),
    .side_b_ctrl_line_oe_o(b_line_oe_o), .side_b_int_request_oe_o(b_irq_oe_o));

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic wr(input logic [1:0] rs, input logic [7:0] d);
    u_cpu.bus_on(1'h1, 1'h0, rs, d);
    cyc(1);
    u_cpu.bus_off();
  endtask

  task automatic rd(input logic [1:0] rs, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    u_cpu.bus_read(rs, v, ok);
    if (!ok) begin
      errors++;
      final_report();
    end else begin
      check(v, exp);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_i = 1'h1;
    reset_n_i = 1'h1;
    ext_a = 8'h3C;
    ext_b = 8'hC3;
    a_irq = 1'h0;
    b_irq = 1'h1;
    ext_a_line = 1'h0;
    ext_b_line = 1'h0;
    cyc(10);
    rst_i = 1'h0;
    cyc(2);
    check(data_oe_o, 8'h00);
    check(port_a_oe_o, 8'h00);
    rd(RS_CTRL_A, 8'h00);
    rd(RS_CTRL_B, 8'h00);
    rd(RS_SIDE_A, 8'h00);
    // direction, access bit and glitch-free output load
    wr(RS_SIDE_A, 8'hF0);
    check(port_a_oe_o, 8'hF0);
    rd(RS_SIDE_A, 8'hF0);
    wr(RS_CTRL_A, 8'h04);
    u_cpu.bus_on(1'h1, 1'h0, RS_SIDE_A, 8'hA5);
    check(port_a_o, 8'h00);
    cyc(1);
    check(port_a_o, 8'h00);
    u_cpu.bus_off();
    check(port_a_o, 8'hA5);
    check(port_a_oe_o, 8'hF0);
    rd(RS_SIDE_A, 8'hAC);
    check(data_oe_o, 8'h00);
    // direction rewritten in mid-run
    wr(RS_CTRL_A, 8'h00);
    wr(RS_SIDE_A, 8'h0F);
    wr(RS_CTRL_A, 8'h04);
    check(port_a_oe_o, 8'h0F);
    rd(RS_SIDE_A, 8'h35);
    // side B on its own
    wr(RS_SIDE_B, 8'h0F);
    wr(RS_CTRL_B, 8'h04);
    wr(RS_SIDE_B, 8'h5A);
    check(port_b_o, 8'h5A);
    check(port_b_oe_o, 8'h0F);
    check(port_a_o, 8'hA5);
    rd(RS_SIDE_B, 8'hCA);
    // unselected accesses are ignored
    u_cpu.bus_on(1'h0, 1'h0, RS_CTRL_A, 8'h3F);
    cyc(1);
    u_cpu.bus_off();
    rd(RS_CTRL_A, 8'h04);
    u_cpu.bus_on(1'h0, 1'h1, RS_CTRL_A, 8'h00);
    cyc(1);
    check(data_oe_o, 8'h00);
    u_cpu.bus_off();
    // interrupt flags from both lines
    wr(RS_CTRL_A, 8'h07);
    a_irq = 1'h1;
    cyc(3);
    check(a_irq_oe_o, 8'h01);
    rd(RS_CTRL_A, 8'h87);
    rd(RS_SIDE_A, 8'h35);
    rd(RS_CTRL_A, 8'h07);
    check(a_irq_oe_o, 8'h00);
    wr(RS_CTRL_B, 8'h1C);
    ext_b_line = 1'h1;
    cyc(3);
    check(b_irq_oe_o, 8'h01);
    rd(RS_CTRL_B, 8'h5C);
    rd(RS_SIDE_B, 8'hCA);
    rd(RS_CTRL_B, 8'h1C);
    // second-line modes
    for (int i = 0; i < 4; i++) begin
      wr(RS_CTRL_A, modes[i]);
      check(a_line_oe_o, mode_exp[i][1]);
      check(a_line_o, mode_exp[i][0]);
    end
    wr(RS_CTRL_A, 8'h2C);
    rd(RS_SIDE_A, 8'h35);
    check(a_line_o, 8'h01);
    wr(RS_CTRL_B, 8'h24);
    check(b_line_oe_o, 8'h01);
    wr(RS_SIDE_B, 8'h3C);
    check(b_line_o, 8'h00);
    b_irq = 1'h0;
    cyc(3);
    check(b_line_o, 8'h01);
    // device reset in mid-run
    reset_n_i = 1'h0;
    cyc(2);
    reset_n_i = 1'h1;
    cyc(1);
    check(port_b_oe_o, 8'h00);
    check(port_b_o, 8'h00);
    rd(RS_CTRL_B, 8'h00);
    rd(RS_SIDE_A, 8'h00);
    final_report();
  end
endmodule
